// File: shared/cme_defines.svh
// constants of the move-or-execute instruction block
`ifndef CME_DEFINES_SVH
`define CME_DEFINES_SVH
`define CME_OPC_W        14
`define CME_DATA_W       8
`define CME_ADDR_W       7
`define CME_OR_PAT       6'h04
`define CME_COPY_PAT     6'h08
`define CME_LIT_PAT      4'hC
`define CME_TGT_BIT      7
`define CME_CLS_MSB      13
`define CME_ACC_RST      8'h00
`define CME_PHASES       4
`endif

// File: shared/cme_pkg.sv
// types of the move-or-execute instruction block
package cme_pkg;
  typedef enum logic [1:0] {
    CME_PH_DECODE  = 2'b00,
    CME_PH_READ    = 2'b01,
    CME_PH_PROCESS = 2'b10,
    CME_PH_WRITE   = 2'b11
  } cme_phase_t;

  typedef enum logic [1:0] {
    CME_OP_NONE = 2'b00,
    CME_OP_OR   = 2'b01,
    CME_OP_COPY = 2'b10,
    CME_OP_LIT  = 2'b11
  } cme_op_t;

  typedef struct packed {
    cme_op_t    op;
    logic       to_cell;
    logic [6:0] addr;
    logic [7:0] imm;
  } cme_dec_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } cme_mem_wr_t;
endpackage

// File: src/cme_decode.sv
// opcode decoder for the move-or-execute instruction block
`timescale 1ns/1ps
`default_nettype none
`include "cme_defines.svh"
module cme_decode (
  input  wire logic [13:0]       opcode_i,
  output cme_pkg::cme_dec_t      dec_o
);
  always_comb begin
    dec_o         = '0;
    dec_o.addr    = opcode_i[`CME_ADDR_W-1:0];
    dec_o.imm     = opcode_i[`CME_DATA_W-1:0];
    dec_o.to_cell = opcode_i[`CME_TGT_BIT];
    // literal load ignores the two bits after its leading pattern
    if (opcode_i[13:10] == `CME_LIT_PAT) begin
      dec_o.op = cme_pkg::CME_OP_LIT;
    end else if (opcode_i[13:8] == `CME_OR_PAT) begin
      dec_o.op = cme_pkg::CME_OP_OR;
    end else if (opcode_i[13:8] == `CME_COPY_PAT) begin
      dec_o.op = cme_pkg::CME_OP_COPY;
    end else begin
      dec_o.op = cme_pkg::CME_OP_NONE;
    end
  end
endmodule
`default_nettype wire

// File: src/cme_core.sv
// four-phase execution of or-with-cell (into cell or accumulator), literal load and cell copy
`timescale 1ns/1ps
`default_nettype none
`include "cme_defines.svh"
module cme_core #(
  parameter int DATA_W = `CME_DATA_W,
  parameter int ADDR_W = `CME_ADDR_W
) (
  input  wire logic              mclk_i,
  input  wire logic              arst_n_i,
  input  wire logic [13:0]       opcode_i,
  input  wire logic [DATA_W-1:0] cell_rdata_i,
  output logic [ADDR_W-1:0]      cell_addr_o,
  output logic                   cell_re_o,
  output logic                   cell_we_o,
  output logic [DATA_W-1:0]      cell_wdata_o,
  output logic [DATA_W-1:0]      acc_o,
  output logic                   null_result_flag_o,
  output logic [1:0]             phase_o,
  output logic                   fetch_o
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  cme_pkg::cme_dec_t dec_w;

  cme_decode cme_decode_i (
    .opcode_i (opcode_i),
    .dec_o    (dec_w)
  );

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cme_pkg::cme_phase_t ph_q, ph_d;
  cme_pkg::cme_dec_t   ins_q, ins_d;
  logic [DATA_W-1:0]   opnd_q, opnd_d;
  logic [DATA_W-1:0]   res_q, res_d;
  logic [DATA_W-1:0]   acc_q, acc_d;
  logic                z_q, z_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic                re_q, re_d;
  logic                we_q, we_d;
  logic [DATA_W-1:0]   wdata_q, wdata_d;
  logic                fetch_q, fetch_d;

  always_comb begin
    ph_d    = ph_q;
    ins_d   = ins_q;
    opnd_d  = opnd_q;
    res_d   = res_q;
    acc_d   = acc_q;
    z_d     = z_q;
    addr_d  = addr_q;
    re_d    = 1'b0;
    we_d    = 1'b0;
    wdata_d = wdata_q;
    fetch_d = 1'b0;
    case (ph_q)
      cme_pkg::CME_PH_DECODE: begin
        ins_d  = dec_w;
        // address held until the next decode so a write-back hits the cell read
        addr_d = dec_w.addr;
        re_d   = (dec_w.op == cme_pkg::CME_OP_OR) || (dec_w.op == cme_pkg::CME_OP_COPY);
        ph_d   = cme_pkg::CME_PH_READ;
      end
      cme_pkg::CME_PH_READ: begin
        // cell data is sampled in the same cycle as the read strobe
        if (ins_q.op == cme_pkg::CME_OP_LIT) begin
          opnd_d = ins_q.imm;
        end else begin
          opnd_d = cell_rdata_i;
        end
        ph_d = cme_pkg::CME_PH_PROCESS;
      end
      cme_pkg::CME_PH_PROCESS: begin
        if (ins_q.op == cme_pkg::CME_OP_OR) begin
          res_d = acc_q | opnd_q;
        end else begin
          res_d = opnd_q;
        end
        ph_d = cme_pkg::CME_PH_WRITE;
      end
      cme_pkg::CME_PH_WRITE: begin
        // write strobe leaves as a registered pulse on the next edge; write data is registered and held
        case (ins_q.op)
          cme_pkg::CME_OP_LIT: begin
            acc_d = res_q;
          end
          cme_pkg::CME_OP_OR, cme_pkg::CME_OP_COPY: begin
            z_d = is_zero(res_q);
            if (ins_q.to_cell) begin
              we_d    = 1'b1;
              wdata_d = res_q;
            end else begin
              acc_d = res_q;
            end
          end
          default: begin
          end
        endcase
        fetch_d = 1'b1;
        ph_d    = cme_pkg::CME_PH_DECODE;
      end
      default: ph_d = cme_pkg::CME_PH_DECODE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_q    <= cme_pkg::CME_PH_DECODE;
      ins_q   <= '0;
      opnd_q  <= '0;
      res_q   <= '0;
      acc_q   <= `CME_ACC_RST;
      z_q     <= 1'b0;
      addr_q  <= '0;
      re_q    <= 1'b0;
      we_q    <= 1'b0;
      wdata_q <= '0;
      fetch_q <= 1'b0;
    end else begin
      ph_q    <= ph_d;
      ins_q   <= ins_d;
      opnd_q  <= opnd_d;
      res_q   <= res_d;
      acc_q   <= acc_d;
      z_q     <= z_d;
      addr_q  <= addr_d;
      re_q    <= re_d;
      we_q    <= we_d;
      wdata_q <= wdata_d;
      fetch_q <= fetch_d;
    end
  end

  assign cell_addr_o        = addr_q;
  assign cell_re_o          = re_q;
  assign cell_we_o          = we_q;
  assign cell_wdata_o       = wdata_q;
  assign acc_o              = acc_q;
  assign null_result_flag_o = z_q;
  assign phase_o            = ph_q;
  assign fetch_o            = fetch_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PHASE_CYCLE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ph_q == cme_pkg::CME_PH_DECODE |=> ph_q == cme_pkg::CME_PH_READ ##1
      ph_q == cme_pkg::CME_PH_PROCESS ##1 ph_q == cme_pkg::CME_PH_WRITE)
    else $error("phase sequence broken");
  AST_LIT_ACC: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_WRITE && ins_q.op == cme_pkg::CME_OP_LIT)
      |=> acc_q == $past(ins_q.imm) && z_q == $past(z_q) && !we_q)
    else $error("literal load wrong");
  AST_LIT_DECODE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_DECODE && opcode_i[13:10] == 4'hC)
      |=> ins_q.op == cme_pkg::CME_OP_LIT)
    else $error("literal not decoded");
  AST_COPY_CELL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_READ && ins_q.op == cme_pkg::CME_OP_COPY && ins_q.to_cell)
      |=> ##2 we_q && cell_wdata_o == $past(cell_rdata_i, 3) && cell_addr_o == ins_q.addr)
    else $error("copy write-back wrong");
  AST_COPY_ACC: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_READ && ins_q.op == cme_pkg::CME_OP_COPY && !ins_q.to_cell)
      |=> ##2 !we_q && acc_q == $past(cell_rdata_i, 3))
    else $error("copy to accumulator wrong");
  AST_COPY_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_WRITE && ins_q.op == cme_pkg::CME_OP_COPY)
      |=> z_q == ($past(res_q) == '0))
    else $error("copy zero flag wrong");
  AST_OR_RESULT: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_PROCESS && ins_q.op == cme_pkg::CME_OP_OR)
      |=> ##1 z_q == (($past(acc_q, 2) | $past(opnd_q, 2)) == '0)
        && (ins_q.to_cell || acc_q == ($past(acc_q, 2) | $past(opnd_q, 2))))
    else $error("or result or zero flag wrong");
  AST_READ_STROBE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cell_re_o |-> ph_q == cme_pkg::CME_PH_READ && ins_q.op != cme_pkg::CME_OP_LIT)
    else $error("read strobe out of phase");
  AST_READ_ADDR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cell_re_o |-> cell_addr_o == ins_q.addr)
    else $error("read address wrong");
  AST_DECODE_ADDR: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_DECODE
      && (dec_w.op == cme_pkg::CME_OP_OR || dec_w.op == cme_pkg::CME_OP_COPY))
      |=> cell_re_o && cell_addr_o == $past(opcode_i[6:0]))
    else $error("operand read not issued");
  AST_RE_PULSE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cell_re_o |=> !cell_re_o)
    else $error("read strobe longer than one cycle");

  // ----------------------------------------------------------------
  // checks of the process, write and decode phases, strobes and fetch
  // ----------------------------------------------------------------
  AST_OR_VALUE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_PROCESS && ins_q.op == cme_pkg::CME_OP_OR)
      |=> res_q == $past(acc_q | opnd_q))
    else $error("or value wrong");
  AST_OR_CELL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_WRITE && ins_q.op == cme_pkg::CME_OP_OR && ins_q.to_cell)
      |=> we_q && cell_wdata_o == $past(res_q) && cell_addr_o == $past(ins_q.addr))
    else $error("or write-back wrong");
  AST_OR_ACC: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_WRITE && ins_q.op == cme_pkg::CME_OP_OR && !ins_q.to_cell)
      |=> !we_q && acc_q == $past(res_q))
    else $error("or to accumulator wrong");
  AST_ACC_HOLD_CELL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_WRITE && ins_q.op != cme_pkg::CME_OP_LIT && ins_q.to_cell)
      |=> acc_q == $past(acc_q))
    else $error("accumulator changed by cell write-back");
  AST_LIT_NO_READ: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_DECODE && dec_w.op == cme_pkg::CME_OP_LIT)
      |=> !cell_re_o)
    else $error("literal load read a cell");
  AST_WE_PULSE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cell_we_o |=> !cell_we_o)
    else $error("write strobe longer than one cycle");
  AST_FETCH_PHASE: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    fetch_o |-> ph_q == cme_pkg::CME_PH_DECODE)
    else $error("fetch outside decode phase");
  AST_NOP_HOLD: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (ph_q == cme_pkg::CME_PH_WRITE && ins_q.op == cme_pkg::CME_OP_NONE)
      |=> acc_q == $past(acc_q) && z_q == $past(z_q) && !we_q)
    else $error("unrecognised opcode changed state");
endmodule
`default_nettype wire

// File: bench/cpu_move_or_execute_tb.sv
// self-checking testbench of the move-or-execute block
`timescale 1ns/1ps
`default_nettype none
module cpu_move_or_execute_tb;
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] acc;
    logic       z;
  } cme_exp_t;
  logic        mclk_i       = 1'b0;
  logic        arst_n_i     = 1'b0;
  logic [13:0] opcode_i     = 14'h0000;
  logic [7:0]  cell_rdata_i = 8'h00;
  logic [6:0]  cell_addr_o;
  logic        cell_re_o;
  logic        cell_we_o;
  logic [7:0]  cell_wdata_o;
  logic [7:0]  acc_o;
  logic        null_result_flag_o;
  logic [1:0]  phase_o;
  logic        fetch_o;
  logic        cur_re       = 1'b0;
  logic [6:0]  cur_addr     = 7'h00;
  int          err_count    = 0;
  int          checks       = 0;
  cme_exp_t    exp_q[$];
  always #2.5 mclk_i = ~mclk_i;
  cme_core cme_core_i (
    .mclk_i             (mclk_i),
    .arst_n_i           (arst_n_i),
    .opcode_i           (opcode_i),
    .cell_rdata_i       (cell_rdata_i),
    .cell_addr_o        (cell_addr_o),
    .cell_re_o          (cell_re_o),
    .cell_we_o          (cell_we_o),
    .cell_wdata_o       (cell_wdata_o),
    .acc_o              (acc_o),
    .null_result_flag_o (null_result_flag_o),
    .phase_o            (phase_o),
    .fetch_o            (fetch_o)
  );
  task automatic finish_test();
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // ------------------------------------------
  // monitor: one note popped per result
  // ------------------------------------------
  always @(posedge mclk_i) begin
    cme_exp_t e;
    if (arst_n_i && phase_o === 2'b01) begin
      check({7'h00, cell_re_o}, {7'h00, cur_re});
      if (cur_re) begin
        check({1'b0, cell_addr_o}, {1'b0, cur_addr});
      end
    end
    if (arst_n_i && fetch_o === 1'b1 && exp_q.size() == 0) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, 1'b1, 1'b0);
    end else if (arst_n_i && fetch_o === 1'b1) begin
      e = exp_q.pop_front();
      check(acc_o, e.acc);
      check({7'h00, null_result_flag_o}, {7'h00, e.z});
      check({7'h00, cell_we_o}, {7'h00, e.we});
      check({6'h00, phase_o}, 8'h00);
      if (e.we) begin
        check({1'b0, cell_addr_o}, {1'b0, e.addr});
        check(cell_wdata_o, e.data);
      end
    end
  end
  // ------------------------------------------
  // driver: random instruction stream
  // ------------------------------------------
  initial begin
    logic [1:0] kind;
    logic       d;
    logic [6:0] f;
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] acc_m;
    logic       z_m;
    cme_exp_t   e;
    acc_m = 8'h00;
    z_m = 1'b0;
    r = 8'h00;
    void'($urandom(32'h21ab_7c4c));
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    for (int n = 0; n < 300; n++) begin
      kind = 2'($urandom());
      d = 1'($urandom());
      f = 7'($urandom());
      v = ($urandom() % 3 == 0) ? 8'h00 : 8'($urandom());
      e = '{we: 1'b0, addr: f, data: 8'h00, acc: 8'h00, z: 1'b0};
      case (kind)
        2'b00: opcode_i <= {2'b01, 12'($urandom())};
        2'b01: opcode_i <= {6'h04, d, f};
        2'b10: opcode_i <= {6'h08, d, f};
        default: opcode_i <= {4'hC, 2'($urandom()), v};
      endcase
      r = (kind == 2'b01) ? (acc_m | v) : v;
      if (kind == 2'b11) begin
        acc_m = v;
      end else if (kind != 2'b00) begin
        z_m = (r == 8'h00);
        e.we = d;
        e.data = r;
        if (!d) begin
          acc_m = r;
        end
      end
      e.acc = acc_m;
      e.z = z_m;
      exp_q.push_back(e);
      cell_rdata_i <= v;
      cur_re <= (kind == 2'b01 || kind == 2'b10);
      cur_addr <= f;
      repeat (4) @(posedge mclk_i);
    end
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
      @(posedge mclk_i);
    end
    if (exp_q.size() > 0) begin
      err_count++;
      $display("Error at %0t: pending %h expected %h", $time, exp_q.size(), 0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
